/* File: inc/acmc_pkg.sv */
`default_nettype none
package acmc_pkg;
    // Register indices; byte address is four times the index
    localparam int          IDX_CONFIG = 1;
    localparam int          IDX_OFFSET = 2;
    localparam int          IDX_RANGE  = 3;
    localparam int          IDX_STATUS = 4;
    localparam logic [11:0] ADDR_CONFIG = 12'(4 * IDX_CONFIG);
    localparam logic [11:0] ADDR_OFFSET = 12'(4 * IDX_OFFSET);
    localparam logic [11:0] ADDR_RANGE  = 12'(4 * IDX_RANGE);
    localparam logic [11:0] ADDR_STATUS = 12'(4 * IDX_STATUS);
    // Values after reset
    localparam logic [15:0] CONFIG_RST = 16'hB2FF;
    localparam logic [15:0] OFFSET_RST = 16'h007F;
    localparam logic [15:0] RANGE_RST  = 16'h807F;
    // Configuration field positions, and offset/range field LSB
    localparam int CFG_DUTY  = 12;
    localparam int CFG_PHASE = 11;
    localparam int CFG_RATE  = 10;
    localparam int CFG_SWING = 9;
    localparam int CFG_EDGE  = 8;
    localparam int FIELD_LSB = 7;
    // Range codes used under pin control
    localparam logic [8:0] RANGE_NORMAL  = 9'h100;
    localparam logic [8:0] RANGE_REDUCED = 9'h000;
    // Cycle and word counts
    localparam int SETTLE_CYC  = 6;
    localparam int DLY_SHORT   = 1024;
    localparam int DLY_LONG    = 4096;
    localparam int CAL_RUN_CYC = 2048;
    localparam int CAL_LOW_CYC = 80;
    localparam int CAL_HI_CYC  = 80;
    localparam int PIPE_WORDS  = 14;

    typedef struct packed {
        logic pd;
        logic cal;
        logic edge_hi;
        logic edge_float;
        logic fsr_hi;
        logic fsr_float;
        logic swing;
        logic dly;
    } acmc_pins_t;

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_WAIT,
        ST_CAL,
        ST_RUN,
        ST_DOWN
    } acmc_state_t;
endpackage : acmc_pkg
`default_nettype wire

/* File: verilog/acmc_top.sv */
// Operation
// RULE_01 - SDR pin edge high: rising launch
// RULE_02 - SDR clock at word rate, DDR half
// RULE_03 - Floating edge pin selects DDR
// RULE_04 - Power-down input high: outputs high impedance
// RULE_05 - Words after power-down marked invalid
// RULE_06 - Running calibration completes before power-down
// RULE_07 - Power-up calibration waits for power-down low
// RULE_08 - Calibration request during power-down ignored
// RULE_09 - Floating range pin selects extended control
// RULE_10 - Host keeps control mode fixed
// RULE_11 - Extended rate from bit 10
// RULE_12 - DDR phase: zero normally, bit 11 extended
// RULE_13 - Extended SDR edge from bit 8
// RULE_14 - Swing from pin, or bit 9
// RULE_15 - Calibration delay: pin chosen, extended short
// RULE_16 - Range: pin, or register three field
// RULE_17 - Offset: none, or register two field
// RULE_18 - Extended defaults set at reset
// RULE_19 - Duty cycle correction enabled by default
// RULE_20 - Rate bit zero DDR, one SDR
// RULE_21 - Extended control ignores mode pins
// RULE_22 - Calibration output high during calibration
// RULE_23 - Mode pins latched once, held stable; code latches only edge_hi, edge_float, fsr_float
//
// Local design decisions: the APB register port and the address map.
`default_nettype none
module acmc_top #(
    parameter int DLY_SHORT_CYC = acmc_pkg::DLY_SHORT,
    parameter int DLY_LONG_CYC  = acmc_pkg::DLY_LONG,
    parameter int CAL_CYC       = acmc_pkg::CAL_RUN_CYC
) (
    input  wire logic                CLK,
    input  wire logic                RSTN,
    input  wire acmc_pkg::acmc_pins_t PINS,
    input  wire logic                SMP_CLK,
    input  wire logic [15:0]         DATA_IN,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [11:0]         PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic [31:0]              PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    output logic                     OUTPUT_DATA_CLOCK_OUT,
    output logic [15:0]              DATA_OUT,
    output logic                     DATA_VALID,
    output logic                     OUT_OE_N,
    output logic                     TRIM_RUNNING,
    output logic                     SWING_NORMAL,
    output logic                     DUTY_FIX_EN,
    output logic [8:0]               RANGE_CODE,
    output logic [8:0]               OFFSET_CODE
);

    ////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [8:0]  s1;
    logic [8:0]  s2;
    logic [8:0]  s3;
    logic [8:0]  stab;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            s1 <= 9'h000;
            s2 <= 9'h000;
            s3 <= 9'h000;
        end else begin
            s1 <= {SMP_CLK, PINS};
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A bit counts once stages two and three agree
    for (genvar i = 0; i < 9; i++) begin : g_stab
        always_ff @(posedge CLK) begin
            if (!RSTN) begin
                stab[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
                stab[i] <= s3[i];
            end
        end
    end

    acmc_pkg::acmc_pins_t pin;
    logic                 smp;
    logic                 smp_q;
    logic                 word_tick;
    logic                 half_tick;

    assign pin       = stab[7:0];
    assign smp       = stab[8];
    assign word_tick = smp & ~smp_q;
    assign half_tick = ~smp & smp_q;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            smp_q <= 1'b0;
        end else begin
            smp_q <= smp;
        end
    end

    ////////////////////////////////////////////////////////////
    // Registers reached over APB

    logic [15:0] cfg;
    logic [15:0] off;
    logic [15:0] rng;
    logic        access;
    logic        ext_q;
    logic        float_q;
    logic        edge_q;
    acmc_pkg::acmc_state_t st;

    assign access = PSEL & PENABLE & ~PREADY;

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            cfg <= acmc_pkg::CONFIG_RST; // RULE_18
            off <= acmc_pkg::OFFSET_RST; // RULE_18
            rng <= acmc_pkg::RANGE_RST;  // RULE_18
        end else if (access && PWRITE) begin
            if (PADDR == acmc_pkg::ADDR_CONFIG) begin
                cfg <= PWDATA[15:0];
            end else if (PADDR == acmc_pkg::ADDR_OFFSET) begin
                off <= PWDATA[15:0];
            end else if (PADDR == acmc_pkg::ADDR_RANGE) begin
                rng <= PWDATA[15:0];
            end
        end
    end

    logic [31:0] next_rdata;
    logic        next_err;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (PADDR == acmc_pkg::ADDR_CONFIG) begin
            next_rdata = {16'h0000, cfg};
        end else if (PADDR == acmc_pkg::ADDR_OFFSET) begin
            next_rdata = {16'h0000, off};
        end else if (PADDR == acmc_pkg::ADDR_RANGE) begin
            next_rdata = {16'h0000, rng};
        end else if (PADDR == acmc_pkg::ADDR_STATUS) begin
            next_rdata = {26'h0000000, DATA_VALID, float_q, ext_q,
                          OUT_OE_N, st == acmc_pkg::ST_DOWN, TRIM_RUNNING};
        end else begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= access;
            PSLVERR <= access & next_err;
            if (access && !PWRITE) begin
                PRDATA <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////
    // Mode selection

    // edge_hi, edge_float and fsr_float sampled every boot cycle, then never resampled
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ext_q   <= 1'b0;
            float_q <= 1'b0;
            edge_q  <= 1'b0;
        end else if (st == acmc_pkg::ST_BOOT) begin // RULE_23
            ext_q   <= pin.fsr_float;  // RULE_09
            float_q <= pin.edge_float; // RULE_03
            edge_q  <= pin.edge_hi;
        end
    end

    logic ddr;
    logic edge_rise;
    logic phase90;

    // Register values replace the pins under extended control
    assign ddr       = ext_q ? ~cfg[acmc_pkg::CFG_RATE] : float_q; // RULE_11 RULE_20 RULE_21
    assign edge_rise = ext_q ? cfg[acmc_pkg::CFG_EDGE] : edge_q;   // RULE_13
    assign phase90   = ext_q & cfg[acmc_pkg::CFG_PHASE];           // RULE_12

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            SWING_NORMAL <= 1'b1;
            DUTY_FIX_EN  <= 1'b1;
            RANGE_CODE   <= acmc_pkg::RANGE_NORMAL;
            OFFSET_CODE  <= 9'h000;
        end else if (ext_q) begin
            SWING_NORMAL <= cfg[acmc_pkg::CFG_SWING];               // RULE_14
            DUTY_FIX_EN  <= cfg[acmc_pkg::CFG_DUTY];                // RULE_19
            RANGE_CODE   <= rng[15:acmc_pkg::FIELD_LSB];            // RULE_16
            OFFSET_CODE  <= off[15:acmc_pkg::FIELD_LSB];            // RULE_17
        end else begin
            SWING_NORMAL <= pin.swing;                              // RULE_14
            DUTY_FIX_EN  <= 1'b1;                                   // RULE_19
            RANGE_CODE   <= pin.fsr_hi ? acmc_pkg::RANGE_NORMAL
                                       : acmc_pkg::RANGE_REDUCED;   // RULE_16
            OFFSET_CODE  <= 9'h000;                                 // RULE_17
        end
    end

    ////////////////////////////////////////////////////////////
    // Manual calibration request detector

    logic [7:0] low_cnt;
    logic [7:0] hi_cnt;
    logic       armed;
    logic       cal_fire;

    assign cal_fire = armed && pin.cal &&
                      hi_cnt == 8'(acmc_pkg::CAL_HI_CYC - 1);

    // Cleared outside run so requests in power-down vanish
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            low_cnt <= 8'h00;
            hi_cnt  <= 8'h00;
            armed   <= 1'b0;
        end else if (st != acmc_pkg::ST_RUN) begin // RULE_08
            low_cnt <= 8'h00;
            hi_cnt  <= 8'h00;
            armed   <= 1'b0;
        end else if (!pin.cal) begin
            hi_cnt <= 8'h00;
            if (low_cnt == 8'(acmc_pkg::CAL_LOW_CYC - 1)) begin
                armed <= 1'b1;
            end else begin
                low_cnt <= low_cnt + 8'h01;
            end
        end else if (armed) begin
            low_cnt <= 8'h00;
            if (cal_fire) begin
                armed  <= 1'b0;
                hi_cnt <= 8'h00;
            end else begin
                hi_cnt <= hi_cnt + 8'h01;
            end
        end else begin
            low_cnt <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////
    // Power and calibration sequencer

    logic [15:0] cnt;
    logic [15:0] dly_last;

    assign dly_last = (!ext_q && pin.dly) ? 16'(DLY_LONG_CYC - 1)
                                          : 16'(DLY_SHORT_CYC - 1); // RULE_15

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            st  <= acmc_pkg::ST_BOOT;
            cnt <= 16'h0000;
        end else begin
            case (st)
                acmc_pkg::ST_BOOT: begin
                    if (cnt == 16'(acmc_pkg::SETTLE_CYC - 1)) begin
                        st  <= acmc_pkg::ST_WAIT;
                        cnt <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                acmc_pkg::ST_WAIT: begin
                    if (pin.pd) begin
                        cnt <= cnt; // RULE_07
                    end else if (cnt >= dly_last) begin
                        st  <= acmc_pkg::ST_CAL;
                        cnt <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                acmc_pkg::ST_CAL: begin
                    if (cnt == 16'(CAL_CYC - 1)) begin
                        st  <= pin.pd ? acmc_pkg::ST_DOWN
                                      : acmc_pkg::ST_RUN; // RULE_06
                        cnt <= 16'h0000;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                acmc_pkg::ST_RUN: begin
                    if (pin.pd) begin
                        st <= acmc_pkg::ST_DOWN; // RULE_04
                    end else if (cal_fire) begin
                        st  <= acmc_pkg::ST_CAL;
                        cnt <= 16'h0000;
                    end
                end
                acmc_pkg::ST_DOWN: begin
                    if (!pin.pd) begin
                        st <= acmc_pkg::ST_RUN;
                    end
                end
                default: begin
                    st <= acmc_pkg::ST_BOOT;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            TRIM_RUNNING <= 1'b0;
            OUT_OE_N     <= 1'b0;
        end else begin
            TRIM_RUNNING <= st == acmc_pkg::ST_CAL; // RULE_22
            OUT_OE_N     <= st == acmc_pkg::ST_DOWN ||
                            (st == acmc_pkg::ST_WAIT && pin.pd); // RULE_04
        end
    end

    ////////////////////////////////////////////////////////////
    // Output clock and data

    logic       run;
    logic [4:0] fill;

    assign run = st == acmc_pkg::ST_RUN;

    // Words still in the refilling pipeline after power-down
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            fill <= 5'h00;
        end else if (st == acmc_pkg::ST_DOWN) begin
            fill <= 5'(acmc_pkg::PIPE_WORDS); // RULE_05
        end else if (run && word_tick && fill != 5'h00) begin
            fill <= fill - 5'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            DATA_OUT   <= 16'h0000;
            DATA_VALID <= 1'b0;
        end else if (!run) begin
            DATA_VALID <= 1'b0;
        end else if (word_tick) begin
            DATA_OUT   <= DATA_IN;
            DATA_VALID <= fill == 5'h00; // RULE_05
        end
    end

    // Clock halted while not running
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            OUTPUT_DATA_CLOCK_OUT <= 1'b0;
        end else if (!run) begin
            OUTPUT_DATA_CLOCK_OUT <= 1'b0;
        end else if (ddr) begin
            if (phase90 ? half_tick : word_tick) begin
                OUTPUT_DATA_CLOCK_OUT <= ~OUTPUT_DATA_CLOCK_OUT; // RULE_02 RULE_12
            end
        end else if (word_tick) begin
            OUTPUT_DATA_CLOCK_OUT <= edge_rise; // RULE_01 RULE_13
        end else if (half_tick) begin
            OUTPUT_DATA_CLOCK_OUT <= ~edge_rise; // RULE_02
        end
    end

    ////////////////////////////////////////////////////////////
    // Assertions

    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);

    a_trim_flag_high: assert property ( // RULE_22
        st == acmc_pkg::ST_CAL |=> TRIM_RUNNING)
        else $error("trim flag low during calibration");

    a_down_hiz: assert property ( // RULE_04
        st == acmc_pkg::ST_DOWN |=> OUT_OE_N && !OUTPUT_DATA_CLOCK_OUT)
        else $error("outputs driven in power-down");

    a_cal_completes: assert property ( // RULE_06
        st == acmc_pkg::ST_CAL && cnt != 16'(CAL_CYC - 1)
        |=> st == acmc_pkg::ST_CAL)
        else $error("calibration cut short");

    a_boot_hold: assert property ( // RULE_07
        st == acmc_pkg::ST_WAIT && pin.pd
        |=> st == acmc_pkg::ST_WAIT && $stable(cnt))
        else $error("power-up delay ran during power-down");

    a_no_cal_down: assert property ( // RULE_08
        st == acmc_pkg::ST_DOWN ##1 st == acmc_pkg::ST_RUN
        |-> !armed ##1 st != acmc_pkg::ST_CAL)
        else $error("calibration request kept across power-down");

    a_mode_stable: assert property ( // RULE_23
        st != acmc_pkg::ST_BOOT |=> $stable(ext_q) && $stable(float_q))
        else $error("mode select changed in operation");

    a_ddr_toggle: assert property ( // RULE_02
        run && ddr && !phase90 && word_tick
        |=> OUTPUT_DATA_CLOCK_OUT != $past(OUTPUT_DATA_CLOCK_OUT))
        else $error("DDR clock did not toggle on word");

    a_sdr_edge: assert property ( // RULE_01
        run && !ddr && word_tick |=> OUTPUT_DATA_CLOCK_OUT == $past(edge_rise))
        else $error("SDR launch edge wrong");

    a_refill: assert property ( // RULE_05
        st == acmc_pkg::ST_DOWN ##1 run |=> !DATA_VALID [*2])
        else $error("data valid right after power-down");

    a_ext_range: assert property ( // RULE_16
        ext_q ##1 ext_q |-> RANGE_CODE == $past(rng[15:7]))
        else $error("range code not from register");

endmodule : acmc_top
`default_nettype wire

/* File: testbench/acmc_capture.sv */
`default_nettype none
// Downstream receiver: samples words on every DDR edge or the SDR non-launch edge and counts clock and data edges
module acmc_capture (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        ddr,
    input  wire logic        lvl,
    input  wire logic        output_data_clock,
    input  wire logic [15:0] data,
    input  wire logic        valid,
    output logic             stb,
    output logic      [15:0] word,
    output int               n_cap,
    output int               n_tog,
    output int               n_chg,
    output int               n_aln
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        prev;
    logic [15:0] prev_w;
    logic        run;
    logic        tog;
    assign tog = output_data_clock != prev;
    ////////////////////////////////////////
    always @(posedge clk) begin
        prev <= output_data_clock;
        prev_w <= data;
        stb <= 1'b0;
        if (clr) begin
            run <= 1'b0;
            n_cap <= 0;
            n_tog <= 0;
            n_chg <= 0;
            n_aln <= 0;
        end else if (valid) begin
            // Any edge in DDR, the non-launch edge in SDR
            if (tog && (ddr || output_data_clock != lvl)) begin
                stb <= 1'b1;
                word <= data;
                run <= 1'b1;
                n_cap <= n_cap + 1;
            end
            if (run && tog) begin
                n_tog <= n_tog + 1;
            end
            if (run && data != prev_w) begin
                n_chg <= n_chg + 1;
                n_aln <= n_aln + ((tog && (ddr || output_data_clock == lvl)) ? 1 : 0);
            end
        end
    end
endmodule : acmc_capture
`default_nettype wire

/* File: testbench/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY_S = 16;
    localparam int DLY_L = 32;
    localparam int CAL_C = 20;
    logic                 CLK, RSTN, SMP_CLK, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic                 OUTPUT_DATA_CLOCK_OUT, DATA_VALID, OUT_OE_N, TRIM_RUNNING, SWING_NORMAL, DUTY_FIX_EN;
    acmc_pkg::acmc_pins_t PINS;
    logic [15:0]          DATA_IN, DATA_OUT, cap_word, w16;
    logic [11:0]          PADDR;
    logic [31:0]          PWDATA, PRDATA;
    logic [8:0]           RANGE_CODE, OFFSET_CODE;
    logic                 cap_clr, cap_ddr, cap_lvl, cap_stb, smp_d;
    int                   n_cap, n_tog, n_chg, n_aln;
    logic [15:0]          drv_q[$];
    int                   idx = -1;
    int                   seed = 15467;
    int                   n_fail = 0;
    int                   checks = 0;
    logic                 lnk = 1'b0;

    acmc_top #(.DLY_SHORT_CYC(DLY_S), .DLY_LONG_CYC(DLY_L), .CAL_CYC(CAL_C)) i_acmc_top (
        .CLK(CLK), .RSTN(RSTN), .PINS(PINS), .SMP_CLK(SMP_CLK), .DATA_IN(DATA_IN),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .OUTPUT_DATA_CLOCK_OUT(OUTPUT_DATA_CLOCK_OUT),
        .DATA_OUT(DATA_OUT), .DATA_VALID(DATA_VALID), .OUT_OE_N(OUT_OE_N),
        .TRIM_RUNNING(TRIM_RUNNING), .SWING_NORMAL(SWING_NORMAL), .DUTY_FIX_EN(DUTY_FIX_EN),
        .RANGE_CODE(RANGE_CODE), .OFFSET_CODE(OFFSET_CODE)
    );
    acmc_capture i_acmc_capture (
        .clk(CLK), .clr(cap_clr), .ddr(cap_ddr), .lvl(cap_lvl), .output_data_clock(OUTPUT_DATA_CLOCK_OUT),
        .data(DATA_OUT), .valid(DATA_VALID), .stb(cap_stb), .word(cap_word),
        .n_cap(n_cap), .n_tog(n_tog), .n_chg(n_chg), .n_aln(n_aln)
    );
    ////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        SMP_CLK = 1'b0;
        #3;
        forever #40 SMP_CLK = ~SMP_CLK;
    end
    // New word just after each sample-clock rise, clear of the capture point
    always @(posedge CLK) begin
        smp_d <= SMP_CLK;
        if (SMP_CLK && !smp_d) begin
            w16 = 16'($random(seed));
            DATA_IN <= w16;
            drv_q.push_back(w16);
        end
    end
    // Each captured word must follow the driven stream without gaps
    always @(posedge CLK) begin
        if (cap_stb === 1'b1 && lnk) begin
            if (idx < 0) begin
                for (int k = drv_q.size() - 1; k >= 0 && idx < 0; k--) begin
                    if (drv_q[k] === cap_word) idx = k;
                end
                chk(idx >= 0, 1);
            end else begin
                idx++;
                chk(cap_word, drv_q[idx]);
            end
        end
    end
    initial begin
        #100_000;
        n_fail++;
        $display("unexpected at %0t: timeout", $time);
        final_report();
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, e);
    endtask : rdchk
    task automatic boot(input acmc_pkg::acmc_pins_t p);
        PINS <= p;
        RSTN <= 1'b0;
        repeat (12) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
    endtask : boot
    task automatic trim_wait(output int n);
        n = 0;
        while (TRIM_RUNNING !== 1'b1 && n < 3000) begin
            @(posedge CLK);
            n++;
        end
    endtask : trim_wait
    task automatic trim_len(output int n, output logic oe);
        n = 0;
        oe = 1'b0;
        while (TRIM_RUNNING === 1'b1 && n < 3000) begin
            @(posedge CLK);
            n++;
            oe |= OUT_OE_N & TRIM_RUNNING;
        end
    endtask : trim_len
    task automatic cal_req;
        PINS.cal <= 1'b0;
        repeat (85) @(posedge CLK);
        PINS.cal <= 1'b1;
        @(posedge CLK);
    endtask : cal_req
    task automatic link(input logic d, input logic l, input logic p90);
        int n;
        repeat (16) @(posedge CLK);
        cap_ddr <= d;
        cap_lvl <= l;
        cap_clr <= 1'b1;
        @(posedge CLK);
        cap_clr <= 1'b0;
        idx = -1;
        @(posedge CLK);
        lnk = 1'b1;
        n = 0;
        while (n_cap < 9 && n < 500) begin
            @(posedge CLK);
            n++;
        end
        lnk = 1'b0;
        chk(n_tog, d ? 8 : 16);
        chk(n_aln, p90 ? 0 : n_chg);
    endtask : link
    ////////////////////////////////////////
    initial begin
        int                   n;
        logic                 oe;
        logic [31:0]          w;
        logic [31:0]          rd;
        logic                 er;
        acmc_pkg::acmc_pins_t p;
        p = '{pd: 1'b1, cal: 1'b0, edge_hi: 1'b1, edge_float: 1'b0, fsr_hi: 1'b1, fsr_float: 1'b0,
              swing: 1'b1, dly: 1'b1};
        PINS = p;
        RSTN = 1'b0;
        DATA_IN = 16'h0000;
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        {cap_clr, cap_ddr, cap_lvl} = 3'b100;
        boot(p);
        chk(DUTY_FIX_EN, 1);
        chk(OFFSET_CODE, 0);
        chk(RANGE_CODE, acmc_pkg::RANGE_NORMAL);
        repeat (100) @(posedge CLK);
        chk(TRIM_RUNNING, 0);
        chk(OUT_OE_N, 1);
        PINS.pd <= 1'b0;
        trim_wait(n);
        chk(n > DLY_L, 1);
        trim_len(n, oe);
        chk(n, CAL_C);
        link(1'b0, 1'b1, 1'b0);
        PINS.swing <= 1'b0;
        PINS.fsr_hi <= 1'b0;
        repeat (10) @(posedge CLK);
        chk(SWING_NORMAL, 0);
        chk(RANGE_CODE, acmc_pkg::RANGE_REDUCED);
        cal_req();
        trim_wait(n);
        PINS.pd <= 1'b1;
        trim_len(n, oe);
        chk(n, CAL_C);
        chk(oe, 0);
        repeat (10) @(posedge CLK);
        chk({OUT_OE_N, OUTPUT_DATA_CLOCK_OUT, DATA_VALID}, 3'b100);
        cal_req();
        repeat (100) @(posedge CLK);
        PINS.pd <= 1'b0;
        n = 0;
        oe = 1'b0;
        while (DATA_VALID !== 1'b1 && n < 400) begin
            @(posedge CLK);
            n++;
            oe |= TRIM_RUNNING;
        end
        chk(oe, 0);
        chk(n >= 104 && n <= 144, 1);
        p.pd = 1'b0;
        p.edge_float = 1'b1;
        p.dly = 1'b0;
        boot(p);
        trim_wait(n);
        chk(n < DLY_L, 1);
        trim_len(n, oe);
        link(1'b1, 1'b0, 1'b0);
        p.edge_float = 1'b0;
        p.edge_hi = 1'b0;
        boot(p);
        trim_wait(n);
        trim_len(n, oe);
        link(1'b0, 1'b0, 1'b0);
        p.fsr_float = 1'b1;
        p.dly = 1'b1;
        boot(p);
        chk(RANGE_CODE, acmc_pkg::RANGE_RST[15:7]);
        chk(OFFSET_CODE, acmc_pkg::OFFSET_RST[15:7]);
        trim_wait(n);
        chk(n < DLY_L, 1);
        trim_len(n, oe);
        rdchk(acmc_pkg::ADDR_CONFIG, acmc_pkg::CONFIG_RST);
        rdchk(acmc_pkg::ADDR_OFFSET, acmc_pkg::OFFSET_RST);
        rdchk(acmc_pkg::ADDR_RANGE, acmc_pkg::RANGE_RST);
        apb(1'b0, 12'h020, 32'h0, rd, er);
        chk(er, 1);
        link(1'b1, 1'b0, 1'b0);
        w = acmc_pkg::CONFIG_RST | (1 << acmc_pkg::CFG_RATE);
        apb(1'b1, acmc_pkg::ADDR_CONFIG, w, rd, er);
        link(1'b0, 1'b0, 1'b0);
        w = (acmc_pkg::CONFIG_RST | (1 << acmc_pkg::CFG_PHASE)) & ~(32'h1 << acmc_pkg::CFG_SWING);
        apb(1'b1, acmc_pkg::ADDR_CONFIG, w, rd, er);
        repeat (3) @(posedge CLK);
        chk(SWING_NORMAL, 0);
        link(1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 3; i++) begin
            w = $random(seed);
            apb(1'b1, acmc_pkg::ADDR_OFFSET, w, rd, er);
            apb(1'b1, acmc_pkg::ADDR_RANGE, ~w, rd, er);
            repeat (3) @(posedge CLK);
            chk(OFFSET_CODE, w[15:7]);
            w = ~w;
            chk(RANGE_CODE, w[15:7]);
            rdchk(acmc_pkg::ADDR_RANGE, {16'h0000, w[15:0]});
        end
        final_report();
    end
endmodule : tb_top
`default_nettype wire
